// ===== bench/ctrl_model.sv
// Controller side of the register port.
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
    input wire logic clk,
    input wire logic rdValid,
    input wire logic [7:0] rdData,
    output var logic [6:0] regAddr = 7'h00,
    output var logic [7:0] regWrData = 8'h00,
    output var logic regWrStb = 1'b0,
    output var logic regRdStb = 1'b0
);
    // Strobes drop low once released; address and data lines go to the inverse of their last value.
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] v, output logic [8:0] r);
        @(posedge clk) {regWrStb, regRdStb, regAddr, regWrData} <= {w, !w, a, v};
        @(posedge clk) {regWrStb, regRdStb, regAddr, regWrData} <= {2'b00, ~a, ~v};
        #1 r = {rdValid, rdData};
    endtask : xfer
endmodule : ctrl_model
`default_nettype wire

// ===== bench/status_props.sv
// Port checker of the status bank.
`timescale 1ns/100ps
`default_nettype none
module status_props (
    input wire logic clk, rst_n, regWrStb, regRdStb, rdValid, frameDone, trackingOk, cfgWrStb, cfgLocked,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] frameQuality, qualityThreshold, rdData,
    input wire logic [2:0] operatingPhase
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    quality_read_a: assert property (frameDone ##1 regRdStb && regAddr == 7'h07
        |=> rdData == $past(frameQuality, 2)) else $error("quality");
    tracking_min_a: assert property (frameDone && qualityThreshold == 8'h00
        |-> ##2 trackingOk == ($past(frameQuality, 2) >= 8'h0A)) else $error("tracking");
    phase_report_a: assert property ((operatingPhase inside {3'h0, 3'h1, 3'h2, 3'h4}) [*2]
        ##0 regRdStb && regAddr == 7'h08 |=> rdData[2:0] == $past(operatingPhase, 2)) else $error("phase");
    reserved_code_a: assert property (rdValid && $past(regAddr) == 7'h08
        |-> rdData[2:0] != 3'h3 && rdData[7:4] == 4'h0) else $error("code");
    sleep_bit_a: assert property (rdValid && $past(regAddr) == 7'h08 && rdData[2:0] != 3'h4
        |-> !rdData[3]) else $error("sleep");
    upper_write_a: assert property (regWrStb && regAddr >= 7'h0A
        |=> cfgWrStb == !$past(cfgLocked)) else $error("write");
    cover property (cfgWrStb);
    cover property (rdValid && rdData == 8'h0C);
    cover property (trackingOk);
endmodule : status_props
`default_nettype wire

// ===== bench/testbench.sv
// Bench of the status bank.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; $display("unexpected %s %h %h", n, e, a); end end
module testbench;
    logic clk = 0, rst_n = 0, frameDone = 0, sleepLevel2 = 0, regWrStb, regRdStb, rdValid, trackingOk, cfgWrStb, cfgLocked;
    logic [6:0] regAddr, cfgAddr;
    logic [7:0] regWrData, rdData, cfgData, frameQuality = 8'h00, qualityThreshold = 8'h00;
    logic [2:0] operatingPhase = 3'h0;
    logic [8:0] r;
    int fail_count = 0, samples_checked = 0;
    always #20 clk = ~clk;
    ctrl_model u_ctrl (.*);
    sensor_status_and_write_lock u_dut (.*);
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic frame_check();
        logic [7:0] t [3] = '{8'h09, 8'h0A, 8'hFF};
        foreach (t[i]) begin
            @(posedge clk) {frameDone, frameQuality} <= {1'b1, t[i]};
            @(posedge clk) frameDone <= 1'b0;
            u_ctrl.xfer(1'b0, 7'h07, 8'h00, r);
            `CHK("quality", {1'b1, t[i]}, r)
            `CHK("tracking", (t[i] >= 8'h0A), trackingOk)
        end
    endtask : frame_check
    task automatic phase_check();
        logic [7:0] t [6] = '{8'h11, 8'h44, 8'h22, 8'hCC, 8'h3C, 8'h00};
        foreach (t[i]) begin
            @(posedge clk) {sleepLevel2, operatingPhase} <= t[i][7:4];
            repeat (2) @(posedge clk);
            u_ctrl.xfer(1'b0, 7'h08, 8'h00, r);
            `CHK("phase", {5'h10, t[i][3:0]}, r)
        end
    endtask : phase_check
    task automatic lock_check();
        u_ctrl.xfer(1'b1, 7'h0A, 8'h3C, r);
        `CHK("locked", 2'b01, {cfgWrStb, cfgLocked})
        u_ctrl.xfer(1'b1, 7'h09, 8'hA5, r);
        u_ctrl.xfer(1'b0, 7'h09, 8'h00, r);
        `CHK("lockreg", 9'h1A5, r)
        u_ctrl.xfer(1'b1, 7'h7F, 8'h5A, r);
        `CHK("open", {2'b10, 7'h7F, 8'h5A}, {cfgWrStb, cfgLocked, cfgAddr, cfgData})
        u_ctrl.xfer(1'b0, 7'h00, 8'h00, r);
        `CHK("unmapped", 9'h000, r)
    endtask : lock_check
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        frame_check();
        phase_check();
        lock_check();
        test_done();
    end
    initial begin
        #40us;
        fail_count++;
        test_done();
    end
endmodule : testbench
bind sensor_status_and_write_lock status_props u_props (.*);
`default_nettype wire

// ===== hw/sensor_status_and_write_lock.sv
// Image quality report, operating phase report and write lock for the upper configuration registers.
//
// Summary of operation
// - Report current frame image quality, 0 to 255.
// - Quality of ten is default tracking minimum.
// - Phase bits 2:0: normal, entering sleep1, sleep2.
// - Never report code 011; 100 means asleep.
// - Sleep level bit valid only while asleep.
`timescale 1ns/100ps
`default_nettype none

`include "sensor_status_regs.svh"

module sensor_status_and_write_lock #(
    parameter sensor_status_pkg::regByte_t unlockValue = `DEFAULT_UNLOCK_VALUE
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register access from the serial port engine.
    input wire sensor_status_pkg::regAddr_t regAddr,
    input wire logic regWrStb,
    input wire sensor_status_pkg::regByte_t regWrData,
    input wire logic regRdStb,
    output logic [7:0] rdData,
    output logic rdValid,
    // Frame quality from the image pipeline.
    input wire logic frameDone,
    input wire sensor_status_pkg::regByte_t frameQuality,
    input wire sensor_status_pkg::regByte_t qualityThreshold,
    output logic trackingOk,
    // Power state from the low power timer.
    input wire sensor_status_pkg::phase_t operatingPhase,
    input wire logic sleepLevel2,
    // Writes passed to the upper configuration registers.
    output logic cfgWrStb,
    output logic [6:0] cfgAddr,
    output logic [7:0] cfgData,
    output logic cfgLocked
);
    import sensor_status_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rstSync_q;
    logic rstLocal_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    assign rstLocal_n = rstSync_q[1];

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic inLockedRange(input regAddr_t a);
        inLockedRange = (a >= `OFS_LOCKED_FIRST) && (a <= `OFS_LOCKED_LAST);
    endfunction : inLockedRange

    function automatic regByte_t phaseReport(input phase_t p, input logic lvl);
        phaseReport = 8'h00;
        phaseReport[`PHASE_FIELD_MSB:`PHASE_FIELD_LSB] = p;
        phaseReport[`SLEEP_LEVEL_BIT] = (p == `PHASE_ASLEEP) ? lvl : 1'b0;
    endfunction : phaseReport

    // ****************************************
    // State update
    // ****************************************
    bank_s state_q;
    bank_s state_d;
    logic unlocked;

    assign unlocked = (state_q.writeLock == unlockValue);

    always_comb begin
        state_d = state_q;
        state_d.rdValid = 1'b0;
        state_d.cfgWrStb = 1'b0;
        if (frameDone) begin
            state_d.quality = frameQuality;
        end
        // A zero threshold falls back to the default minimum.
        if (qualityThreshold == 8'h00) begin
            state_d.trackingOk = state_q.quality >= `DEFAULT_MIN_QUALITY;
        end else begin
            state_d.trackingOk = state_q.quality >= qualityThreshold;
        end
        case (operatingPhase)
            `PHASE_NORMAL, `PHASE_ENTER_SLEEP1, `PHASE_ENTER_SLEEP2: begin
                state_d.phase = operatingPhase;
            end
            `PHASE_ASLEEP: begin
                state_d.phase = operatingPhase;
                state_d.sleepLevel = sleepLevel2;
            end
            default: begin
                // Reserved and undefined codes keep the last valid phase.
                state_d.phase = state_q.phase;
            end
        endcase
        if (regWrStb) begin
            if (regAddr == `OFS_CONFIG_WRITE_LOCK) begin
                state_d.writeLock = regWrData;
            end else if (inLockedRange(regAddr) && unlocked) begin
                state_d.cfgWrStb = 1'b1;
                state_d.cfgAddr = regAddr;
                state_d.cfgData = regWrData;
            end
        end
        if (regRdStb) begin
            case (regAddr)
                `OFS_FRAME_IMAGE_QUALITY: begin
                    state_d.rdData = state_q.quality;
                    state_d.rdValid = 1'b1;
                end
                `OFS_OPERATING_PHASE_REPORT: begin
                    state_d.rdData = phaseReport(state_q.phase, state_q.sleepLevel);
                    state_d.rdValid = 1'b1;
                end
                `OFS_CONFIG_WRITE_LOCK: begin
                    state_d.rdData = state_q.writeLock;
                    state_d.rdValid = 1'b1;
                end
                default: begin
                    state_d.rdData = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            state_q <= '0;
            state_q.quality <= `RST_FRAME_IMAGE_QUALITY;
            state_q.phase <= `PHASE_NORMAL;
            state_q.writeLock <= `RST_CONFIG_WRITE_LOCK;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdData = state_q.rdData;
    assign rdValid = state_q.rdValid;
    assign trackingOk = state_q.trackingOk;
    assign cfgWrStb = state_q.cfgWrStb;
    assign cfgAddr = state_q.cfgAddr;
    assign cfgData = state_q.cfgData;
    assign cfgLocked = !unlocked;

endmodule : sensor_status_and_write_lock

`default_nettype wire

// ===== shared/sensor_status_pkg.sv
// Types shared by the status and write-lock bank.
`default_nettype none

package sensor_status_pkg;

    typedef logic [6:0] regAddr_t;
    typedef logic [7:0] regByte_t;
    typedef logic [2:0] phase_t;

    typedef struct packed {
        regByte_t quality;
        phase_t phase;
        logic sleepLevel;
        regByte_t writeLock;
        regByte_t rdData;
        logic rdValid;
        logic cfgWrStb;
        regAddr_t cfgAddr;
        regByte_t cfgData;
        logic trackingOk;
    } bank_s;

endpackage : sensor_status_pkg

`default_nettype wire

// ===== shared/sensor_status_regs.svh
// Register offsets, field positions, reset values and fixed codes of the status and write-lock bank.
`ifndef SENSOR_STATUS_REGS_SVH
`define SENSOR_STATUS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_FRAME_IMAGE_QUALITY 7'h07
`define OFS_OPERATING_PHASE_REPORT 7'h08
`define OFS_CONFIG_WRITE_LOCK 7'h09
`define OFS_LOCKED_FIRST 7'h0A
`define OFS_LOCKED_LAST 7'h7F

// ****************************************
// Field positions
// ****************************************
`define PHASE_FIELD_LSB 0
`define PHASE_FIELD_MSB 2
`define SLEEP_LEVEL_BIT 3

// ****************************************
// Operating phase codes
// ****************************************
`define PHASE_NORMAL 3'h0
`define PHASE_ENTER_SLEEP1 3'h1
`define PHASE_ENTER_SLEEP2 3'h2
`define PHASE_RESERVED 3'h3
`define PHASE_ASLEEP 3'h4

// ****************************************
// Reset values and limits
// ****************************************
`define RST_FRAME_IMAGE_QUALITY 8'h00
`define RST_CONFIG_WRITE_LOCK 8'h00
`define DEFAULT_MIN_QUALITY 8'h0A
`define DEFAULT_UNLOCK_VALUE 8'hA5

`endif
